/* File: logic/iac_pkg.sv */
// package: register map, field layout and reset values of the indirect address control
package iac_pkg;
  localparam logic [7:0] ADDR_HIGH_OFS = 8'h6E;
  localparam logic [7:0] ADDR_LOW_OFS = 8'h6F;
  localparam logic [7:0] DATA_FIRST_OFS = 8'h70;
  localparam logic [7:0] DATA_LAST_OFS = 8'h78;
  localparam int DATA_BYTES = 9;
  localparam int FSEL_MSB = 6;
  localparam int FSEL_LSB = 5;
  localparam int RDWR_BIT = 4;
  localparam int TSEL_MSB = 3;
  localparam int TSEL_LSB = 2;
  localparam int MID_MSB = 1;
  localparam int MID_LSB = 0;
  localparam logic [7:0] HIGH_RST = 8'h00;
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] FSEL_TABLE = 2'h0;
  localparam logic [3:0] PORT_GLOBAL = 4'h0;
  typedef enum logic [1:0] {
    IAC_TBL_STATIC,
    IAC_TBL_VLAN,
    IAC_TBL_DYNAMIC,
    IAC_TBL_MIB
  } iac_table_t;
endpackage : iac_pkg

/* File: logic/iac_cmd_if.sv */
// interface: launched command between register bank and address decoder
interface iac_cmd_if;
  logic [7:0] high;
  logic [7:0] low;
  logic table_mode;
  logic [1:0] table_sel;
  logic [11:0] ind_addr;
  logic [3:0] port_sel;
  logic [7:0] reg_ptr;
  modport bank (output high, output low, input table_mode, input table_sel,
    input ind_addr, input port_sel, input reg_ptr);
  modport dec (input high, input low, output table_mode, output table_sel,
    output ind_addr, output port_sel, output reg_ptr);
endinterface : iac_cmd_if

/* File: logic/iac_addr_decode.sv */
// module: combinational decode of the control bytes into table or indirect address
module iac_addr_decode (
  iac_cmd_if.dec cmd
);
  assign cmd.table_mode = (cmd.high[iac_pkg::FSEL_MSB:iac_pkg::FSEL_LSB] == iac_pkg::FSEL_TABLE);
  assign cmd.table_sel = cmd.high[iac_pkg::TSEL_MSB:iac_pkg::TSEL_LSB];
  // upper bits zeroed in table mode
  assign cmd.ind_addr = {cmd.table_mode ? 2'h0 : cmd.high[iac_pkg::TSEL_MSB:iac_pkg::TSEL_LSB],
    cmd.high[iac_pkg::MID_MSB:iac_pkg::MID_LSB], cmd.low};
  assign cmd.port_sel = cmd.ind_addr[11:8];
  assign cmd.reg_ptr = cmd.ind_addr[7:0];
endmodule : iac_addr_decode

/* File: logic/iac_bank.sv */
// module: indirect access address control register bank with command launch
module iac_bank (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [71:0] entry_rdata,
  output logic [7:0] rdata,
  output logic cmd_go,
  output logic cmd_read,
  output logic cmd_table_mode,
  output logic [1:0] cmd_table,
  output logic [1:0] cmd_func,
  output logic [11:0] cmd_addr,
  output logic [3:0] cmd_port,
  output logic cmd_port_global,
  output logic [7:0] cmd_ptr,
  output logic [71:0] entry_wdata
);
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic [8:0][7:0] data;
    logic [7:0] rdata;
    logic go;
    logic rd;
    logic tmode;
    logic [1:0] tsel;
    logic [1:0] func;
    logic [11:0] addr;
    logic [3:0] port;
    logic glob;
    logic [7:0] ptr;
  } iac_state_t;

  iac_state_t st_r;
  iac_state_t st_nxt;
  iac_cmd_if cmd ();

  assign cmd.high = st_r.high;
  assign cmd.low = st_r.low;
  // decode of what would be launched now; low byte of next write substituted below
  iac_addr_decode u_dec (
    .cmd(cmd)
  );

  // byte index of a data register, the last data reg (DATA_LAST_OFS) holds entry bits 7:0
  function automatic logic [3:0] data_idx(input logic [7:0] a);
    logic [7:0] d;
    d = iac_pkg::DATA_LAST_OFS - a;
    data_idx = d[3:0];
  endfunction : data_idx

  function automatic logic is_data(input logic [7:0] a);
    is_data = (a >= iac_pkg::DATA_FIRST_OFS) && (a <= iac_pkg::DATA_LAST_OFS);
  endfunction : is_data

  // next state: register writes, read mux, command launch
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.go = 1'b0;
    if (wr_en && addr == iac_pkg::ADDR_HIGH_OFS)
    begin
      st_nxt.high = wdata;
    end
    if (wr_en && is_data(addr))
    begin
      st_nxt.data[data_idx(addr)] = wdata;
    end
    if (wr_en && addr == iac_pkg::ADDR_LOW_OFS)
    begin
      st_nxt.low = wdata;
      st_nxt.go = 1'b1;
      st_nxt.rd = st_r.high[iac_pkg::RDWR_BIT];
      st_nxt.tmode = cmd.table_mode;
      st_nxt.tsel = cmd.table_sel;
      st_nxt.func = st_r.high[iac_pkg::FSEL_MSB:iac_pkg::FSEL_LSB];
      // launched address uses the new low byte
      st_nxt.addr = {cmd.ind_addr[11:8], wdata};
      st_nxt.port = cmd.ind_addr[11:8];
      st_nxt.ptr = wdata;
      st_nxt.glob = (cmd.ind_addr[11:8] == iac_pkg::PORT_GLOBAL);
    end
    // a completed read cycle returns the entry into the data bytes
    if (st_r.go && st_r.rd)
    begin
      st_nxt.data = entry_rdata;
    end
    if (rd_en)
    begin
      if (addr == iac_pkg::ADDR_HIGH_OFS)
      begin
        st_nxt.rdata = st_r.high;
      end
      else if (addr == iac_pkg::ADDR_LOW_OFS)
      begin
        st_nxt.rdata = st_r.low;
      end
      else if (is_data(addr))
      begin
        st_nxt.rdata = st_r.data[data_idx(addr)];
      end
      else
      begin
        st_nxt.rdata = 8'h00; // unmapped reads as zero
      end
    end
  end

  // state register; ce low freezes everything including the launch pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign cmd_go = st_r.go;
  assign cmd_read = st_r.rd;
  assign cmd_table_mode = st_r.tmode;
  assign cmd_table = st_r.tsel;
  assign cmd_func = st_r.func;
  assign cmd_addr = st_r.addr;
  assign cmd_port = st_r.port;
  assign cmd_port_global = st_r.glob;
  assign cmd_ptr = st_r.ptr;
  assign entry_wdata = st_r.data;

  // a low write gives a go pulse next cycle
  AST_LAUNCH: assert property (@(posedge clk) disable iff (!rst_n)
    ce && wr_en && addr == iac_pkg::ADDR_LOW_OFS |=> cmd_go && cmd_ptr == $past(wdata))
    else $error("low write did not launch");
  // no go without a low write; a pulse held by a frozen bank is not a new launch
  AST_NO_SPURIOUS: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_go && $past(ce) |-> $past(wr_en && addr == iac_pkg::ADDR_LOW_OFS))
    else $error("spurious launch");
  // go lasts one enabled cycle unless another low write follows
  AST_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_go && ce && !(wr_en && addr == iac_pkg::ADDR_LOW_OFS) |=> !cmd_go)
    else $error("launch pulse too long");
  AST_DIR: assert property (@(posedge clk) disable iff (!rst_n)
    ce && wr_en && addr == iac_pkg::ADDR_LOW_OFS
    |=> cmd_read == $past(st_r.high[iac_pkg::RDWR_BIT]))
    else $error("direction wrong");
  // table mode when function is zero
  AST_TABLE: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_go |-> cmd_table_mode == (cmd_func == 2'h0))
    else $error("table mode wrong");
  // upper address bits zero in table mode
  AST_UPPER: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_go && cmd_table_mode |-> cmd_addr[11:10] == 2'h0)
    else $error("upper bits leaked");
  // upper bits equal table field otherwise
  AST_CONCAT: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_go && !cmd_table_mode |-> cmd_addr[11:10] == cmd_table)
    else $error("address concat wrong");
  AST_GLOBAL: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_go |-> cmd_port_global == (cmd_port == 4'h0))
    else $error("global decode wrong");
  AST_RDHIGH: assert property (@(posedge clk) disable iff (!rst_n)
    ce && rd_en && addr == iac_pkg::ADDR_HIGH_OFS |=> rdata == $past(st_r.high))
    else $error("high readback wrong");
  AST_RDLOW: assert property (@(posedge clk) disable iff (!rst_n)
    ce && rd_en && addr == iac_pkg::ADDR_LOW_OFS && !wr_en |=> rdata == $past(st_r.low))
    else $error("low readback wrong");
  // port and pointer are the upper four and lower eight bits of the launched address
  AST_SPLIT: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_go |-> cmd_port == cmd_addr[11:8] && cmd_ptr == cmd_addr[7:0])
    else $error("port split wrong");

  // read command steps: low write with the read bit set, then the go pulse taken
  sequence seq_rd_launch;
    ce && wr_en && addr == iac_pkg::ADDR_LOW_OFS && st_r.high[iac_pkg::RDWR_BIT];
  endsequence
  sequence seq_go_taken;
    cmd_go && ce;
  endsequence
  // entry lands in the data bytes right after a read launch
  AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
    seq_rd_launch ##1 seq_go_taken |=> entry_wdata == $past(entry_rdata))
    else $error("entry not reloaded after read");
  // a write command leaves the data bytes to software
  AST_KEEP_DATA: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_go && !cmd_read && ce && !(wr_en && is_data(addr)) |=> $stable(entry_wdata))
    else $error("data bytes changed by write command");
  // a frozen bank neither launches nor moves its outputs
  AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> $stable(cmd_go) && $stable(cmd_addr) && $stable(rdata) && $stable(entry_wdata))
    else $error("frozen bank changed");
endmodule : iac_bank

/* File: sim/indirect_access_address_control_tb.sv */
// testbench: register-level checks of the indirect access address control bank
module indirect_access_address_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, ce, wr_en, rd_en, cmd_go, cmd_read, cmd_table_mode, cmd_port_global;
  logic [7:0] addr, wdata, rdata, cmd_ptr;
  logic [71:0] entry_rdata, entry_wdata;
  logic [1:0] cmd_table, cmd_func;
  logic [11:0] cmd_addr;
  logic [3:0] cmd_port;
  int err_count, tests_run, cyc;

  iac_bank DUT (.clk, .rst_n, .ce, .wr_en, .rd_en, .addr, .wdata, .entry_rdata, .rdata,
    .cmd_go, .cmd_read, .cmd_table_mode, .cmd_table, .cmd_func, .cmd_addr, .cmd_port,
    .cmd_port_global, .cmd_ptr, .entry_wdata);

  // free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // strobe stays high on return so writes can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    chk(rdata, exp);
    @(negedge clk);
  endtask : rd

  // upper byte then lower byte; the lower write must fire exactly one pulse
  task automatic launch(input logic [7:0] h, input logic [7:0] l);
    wr(iac_pkg::ADDR_HIGH_OFS, h);
    wr(iac_pkg::ADDR_LOW_OFS, l);
    wr_en = 1'b0;
    chk(cmd_go, 1'b1);
    @(negedge clk);
    chk(cmd_go, 1'b0);
  endtask : launch

  // hang guard, the whole run needs under two hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_count++;
      give_verdict();
    end
  end

  initial
  begin
    logic [1:0] f;
    logic [7:0] lo;
    rst_n = 1'b0;
    ce = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    entry_rdata = 72'h0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    rd(iac_pkg::ADDR_HIGH_OFS, 8'h00);
    rd(iac_pkg::ADDR_LOW_OFS, 8'h00);
    // every table code with a write command
    for (int t = 0; t < 4; t++)
    begin
      launch({3'h0, 1'b0, t[1:0], 2'h3}, 8'hA5);
      chk({cmd_table_mode, cmd_table, cmd_func, cmd_read}, {1'b1, t[1:0], 3'h0});
      chk(cmd_addr, 12'h3A5);
    end
    // every port code under the nonzero function codes
    for (int p = 0; p < 16; p++)
    begin
      f = 2'(p % 3 + 1);
      lo = 8'h5A ^ 8'(p * 17);
      launch({1'b0, f, p[0], p[3:0]}, lo);
      chk({cmd_table_mode, cmd_func, cmd_read}, {1'b0, f, p[0]});
      chk(cmd_addr, {p[3:0], lo});
      chk({cmd_port, cmd_port_global, cmd_ptr}, {p[3:0], p == 0, lo});
      rd(iac_pkg::ADDR_HIGH_OFS, {1'b0, f, p[0], p[3:0]});
      rd(iac_pkg::ADDR_LOW_OFS, lo);
    end
    // data bytes out with a write command, then reloaded by a read command
    for (int i = 0; i < 9; i++)
      wr(iac_pkg::DATA_FIRST_OFS + 8'(i), 8'(i + 1));
    launch(8'h20, 8'h10);
    chk(entry_wdata, 72'h010203040506070809);
    entry_rdata = 72'hF0E1D2C3B4A5968778;
    launch(8'h50, 8'h01);
    rd(iac_pkg::DATA_FIRST_OFS, 8'hF0);
    rd(iac_pkg::DATA_LAST_OFS, 8'h78);
    // unmapped offset ignored, then a frozen bank must not launch
    wr(8'h80, 8'hFF);
    wr_en = 1'b0;
    @(negedge clk);
    rd(8'h80, 8'h00);
    ce = 1'b0;
    wr(iac_pkg::ADDR_LOW_OFS, 8'hC3);
    wr_en = 1'b0;
    chk(cmd_go, 1'b0);
    @(negedge clk);
    ce = 1'b1;
    rd(iac_pkg::ADDR_LOW_OFS, 8'h01);
    // reset in mid-run clears the address fields again
    rst_n = 1'b0;
    @(negedge clk);
    chk({cmd_addr, cmd_go, cmd_read}, 14'h0);
    rst_n = 1'b1;
    rd(iac_pkg::ADDR_HIGH_OFS, 8'h00);
    rd(iac_pkg::ADDR_LOW_OFS, 8'h00);
    give_verdict();
  end
endmodule : indirect_access_address_control_tb
